// *** design/scc_pkg.sv ***
// Purpose: shared constants and types for the switched supply control ends
// Assumes: byte-wide module bus, one clock, synchronous reset
// Notes:   supply index 0..3 = logic, low program, high program, negative

package scc_pkg;

	// ==========================================================
	// module bus
	localparam int          NUM_SUPPLY    = 4;
	localparam int          MOD_PORTS     = 16;
	localparam int          MOD_IDX_W     = 4;
	localparam logic [7:0]  PORT_STATUS   = 8'h02;
	localparam logic [7:0]  PORT_LATCH    = 8'h03;
	localparam logic [7:0]  PORT_DIRECT   = 8'hE3;
	localparam logic [7:0]  PORT_MOD_FIRST = 8'h10;
	localparam logic [7:0]  PORT_MOD_LAST = 8'h1F;
	localparam logic [7:0]  PORT_MOD_CTL0 = 8'h10;
	localparam logic [7:0]  PORT_MOD_CTL1 = 8'h11;
	localparam logic [7:0]  UPLOAD_MASK   = 8'h02;
	localparam int          LATCH_CLK_BIT = 0;
	localparam int          SEL_LSB       = 1;
	localparam int          DIRECT_LSB    = 0;
	localparam logic [7:0]  BYTE_ZERO     = 8'h00;

	// ==========================================================
	// host registers (AXI4-Lite, byte addresses)
	localparam int          AXI_ADDR_W    = 4;
	localparam logic [3:0]  REG_CMD       = 4'h0;
	localparam logic [3:0]  REG_STATUS    = 4'h4;
	localparam int          CMD_DATA_LSB  = 0;
	localparam int          CMD_ADDR_LSB  = 8;
	localparam int          CMD_OP_LSB    = 24;
	localparam int          ST_BUSY_BIT   = 0;
	localparam int          ST_PWR_BIT    = 1;
	localparam int          ST_RD_LSB     = 8;
	localparam int          ST_SHADOW_LSB = 16;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	localparam logic [2:0]  STEP_CLR_PWR  = 3'h1;

	typedef enum logic [1:0] {
		OP_WRITE  = 2'h0,
		OP_READ   = 2'h1,
		OP_SUPPLY = 2'h2,
		OP_PDOWN  = 2'h3
	} scc_op_t;

	typedef struct packed {
		logic       act;
		logic       rd;
		logic       last;
		logic       clr_pwr;
		logic [7:0] addr;
		logic [7:0] data;
	} scc_step_t;

endpackage

// *** design/scc_bus_if.sv ***
// Purpose: byte-wide module bus between host end and device end
// Assumes: one clock; strobes are one-cycle pulses
// Notes:   read answer marked by rvalid

`timescale 1ns/1ns
`default_nettype none

interface scc_bus_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       rvalid;

	modport dev  (input addr, wdata, wr, rd, output rdata, rvalid);
	modport host (output addr, wdata, wr, rd, input rdata, rvalid);
endinterface

`default_nettype wire

// *** design/scc_dev_end.sv ***
// Purpose: device end of switched supply control with module port decode
// Assumes: bus strobes synchronous to CLK_SYS_I, one cycle each
// Notes:   BENCH selects latch-clocked (1) or direct-write (0) variant

`timescale 1ns/1ns
`default_nettype none

module scc_dev_end #(
	parameter bit BENCH = 1'b1
) (
	input  wire logic                           CLK_SYS_I,
	input  wire logic                           SRST_I,
	scc_bus_if.dev                              BUS,
	input  wire logic [scc_pkg::NUM_SUPPLY-1:0] OVERCURRENT_I,
	output logic      [scc_pkg::NUM_SUPPLY-1:0] SUPPLY_O,
	output logic      [scc_pkg::MOD_PORTS-1:0]  MOD_WR_STB_O,
	output logic      [scc_pkg::MOD_PORTS-1:0]  MOD_RD_STB_O,
	output logic      [7:0]                     MOD_WDATA_O,
	input  wire logic [7:0]                     MOD_RDATA_I
);
	import scc_pkg::*;

	// ==========================================================
	// decode helpers
	function automatic logic [MOD_PORTS-1:0] mod_onehot(input logic [7:0] a);
		logic [7:0] off;
		off        = a - PORT_MOD_FIRST;
		mod_onehot = '0;
		if (a >= PORT_MOD_FIRST && a <= PORT_MOD_LAST) begin
			mod_onehot[off[MOD_IDX_W-1:0]] = 1'b1;
		end
	endfunction

	function automatic logic is_mod(input logic [7:0] a);
		is_mod = (a >= PORT_MOD_FIRST && a <= PORT_MOD_LAST);
	endfunction

	logic [NUM_SUPPLY-1:0] supply;
	logic                  latch_clk;
	logic                  latch_fall;
	logic                  direct_wr;
	logic                  rd_q;
	logic [7:0]            rd_addr_q;
	logic [7:0]            rdata;
	logic                  rvalid;
	logic [MOD_PORTS-1:0]  mod_wr;
	logic [MOD_PORTS-1:0]  mod_rd;
	logic [7:0]            mod_wdata;

	// ==========================================================
	// latch clock bit
	// [RULE5] track latch clock
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I) begin
			latch_clk <= 1'b0;
		end else if (BENCH && BUS.wr && BUS.addr == PORT_LATCH) begin
			latch_clk <= BUS.wdata[LATCH_CLK_BIT];
		end
	end

	// [RULE5] falling edge only
	assign latch_fall = BENCH && BUS.wr && BUS.addr == PORT_LATCH &&
		latch_clk && !BUS.wdata[LATCH_CLK_BIT];

	// [RULE8] direct write path
	assign direct_wr = !BENCH && BUS.wr && BUS.addr == PORT_DIRECT;

	// ==========================================================
	// supply flip-flops, one per line
	for (genvar i = 0; i < NUM_SUPPLY; i++) begin : g_line
		// [RULE1] independent line control
		always_ff @(posedge CLK_SYS_I) begin
			if (SRST_I) begin
				// [RULE14] off after reset
				supply[i] <= 1'b0;
			end else if (BENCH && OVERCURRENT_I[i]) begin
				// [RULE7] over-current shutdown
				supply[i] <= 1'b0;
			end else if (latch_fall) begin
				// [RULE5] capture selects
				supply[i] <= BUS.wdata[SEL_LSB+i];
			end else if (direct_wr) begin
				// [RULE8] single write applies
				supply[i] <= BUS.wdata[DIRECT_LSB+i];
			end
		end
	end

	assign SUPPLY_O = supply;

	// ==========================================================
	// module port strobes
	// [RULE10] write strobe per port
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I) begin
			mod_wr <= '0;
		end else if (BUS.wr) begin
			mod_wr <= mod_onehot(BUS.addr);
		end else begin
			mod_wr <= '0;
		end
	end

	// [RULE10] read strobe per port
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I) begin
			mod_rd <= '0;
		end else if (BUS.rd) begin
			mod_rd <= mod_onehot(BUS.addr);
		end else begin
			mod_rd <= '0;
		end
	end

	// [RULE11] byte-wide data out
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I) begin
			mod_wdata <= BYTE_ZERO;
		end else if (BUS.wr && is_mod(BUS.addr)) begin
			mod_wdata <= BUS.wdata;
		end
	end

	assign MOD_WR_STB_O = mod_wr;
	assign MOD_RD_STB_O = mod_rd;
	assign MOD_WDATA_O  = mod_wdata;

	// ==========================================================
	// read path, answer two edges after the request
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I) begin
			rd_q      <= 1'b0;
			rd_addr_q <= BYTE_ZERO;
		end else begin
			rd_q      <= BUS.rd;
			rd_addr_q <= BUS.rd ? BUS.addr : rd_addr_q;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I) begin
			rvalid <= 1'b0;
		end else begin
			rvalid <= rd_q;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I) begin
			rdata <= BYTE_ZERO;
		end else if (rd_q) begin
			if (BENCH && rd_addr_q == PORT_STATUS) begin
				// [RULE6] line states readable
				rdata <= 8'(supply) << SEL_LSB;
			end else if (is_mod(rd_addr_q)) begin
				// [RULE9] module port read
				rdata <= MOD_RDATA_I;
			end else begin
				rdata <= BYTE_ZERO;
			end
		end
	end

	assign BUS.rdata  = rdata;
	assign BUS.rvalid = rvalid;

endmodule

`default_nettype wire

// *** design/scc_host_end.sv ***
// Purpose: host end; runs port sequences ordered over AXI4-Lite
// Assumes: one clock; device answers reads via rvalid
// Notes:   write commands while busy are ignored
//
// Function
// [RULE1] four supply lines, each switched independently
// [RULE2] host writes latch port twice per change
// [RULE3] first write: clock bit one, selects set
// [RULE4] second write: same selects, clock bit zero
// [RULE5] selects captured only on clock falling edge
// [RULE6] status port returns the four line states; the direct variant reads the status port as zero
// [RULE7] over-current turns that line off itself; the direct variant ignores OVERCURRENT_I
// [RULE8] direct variant: single write to direct port
// [RULE9] module ports decoded at 10h through 1Fh
// [RULE10] separate read and write strobe per port
// [RULE11] all bus transfers are one byte wide
// [RULE12] host powers down in fixed order
// [RULE13] module may shut itself down beforehand
// [RULE14] after reset all supplies off, latches zero

`timescale 1ns/1ns
`default_nettype none

module scc_host_end #(
	parameter bit BENCH = 1'b1
) (
	input  wire logic                           CLK_SYS_I,
	input  wire logic                           SRST_I,
	scc_bus_if.host                             BUS,
	input  wire logic [scc_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic                           S_AXI_AWVALID,
	output logic                                S_AXI_AWREADY,
	input  wire logic [31:0]                    S_AXI_WDATA,
	input  wire logic [3:0]                     S_AXI_WSTRB,
	input  wire logic                           S_AXI_WVALID,
	output logic                                S_AXI_WREADY,
	output logic      [1:0]                     S_AXI_BRESP,
	output logic                                S_AXI_BVALID,
	input  wire logic                           S_AXI_BREADY,
	input  wire logic [scc_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic                           S_AXI_ARVALID,
	output logic                                S_AXI_ARREADY,
	output logic      [31:0]                    S_AXI_RDATA,
	output logic      [1:0]                     S_AXI_RRESP,
	output logic                                S_AXI_RVALID,
	input  wire logic                           S_AXI_RREADY
);
	import scc_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_EXEC = 4'b0010,
		ST_GAP  = 4'b0100,
		ST_RDW  = 4'b1000
	} scc_hstate_t;

	// ==========================================================
	// sequence table
	function automatic scc_step_t step_of(input scc_op_t op, input logic [2:0] n,
		input logic [7:0] a, input logic [7:0] d, input logic [7:0] shadow);
		logic [2:0] k;
		logic [7:0] sel;
		step_of = '0;
		k       = n;
		sel     = d;
		if (op == OP_PDOWN) begin
			// [RULE12] ordered power-down
			if (n == 3'h0) begin
				step_of = '{1'b1, 1'b0, 1'b0, 1'b0, PORT_MOD_CTL1, BYTE_ZERO};
			end else if (n == STEP_CLR_PWR) begin
				step_of = '{1'b0, 1'b0, 1'b0, 1'b1, BYTE_ZERO, BYTE_ZERO};
			end else if (n == 3'h2) begin
				step_of = '{1'b1, 1'b0, 1'b0, 1'b0, PORT_MOD_CTL0, shadow & UPLOAD_MASK};
			end
			k   = n - 3'h3;
			sel = BYTE_ZERO;
		end
		if (op == OP_WRITE || op == OP_READ) begin
			step_of = '{1'b1, op == OP_READ, 1'b1, 1'b0, a, d};
		end else if ((op == OP_SUPPLY || n >= 3'h3) && BENCH) begin
			// [RULE2] two latch writes
			if (k == 3'h0) begin
				// [RULE3] clock high, selects set
				step_of = '{1'b1, 1'b0, 1'b0, 1'b0, PORT_LATCH, (sel << SEL_LSB) | 8'h01};
			end else begin
				// [RULE4] clock low, selects kept
				step_of = '{1'b1, 1'b0, 1'b1, 1'b0, PORT_LATCH, sel << SEL_LSB};
			end
		end else if (op == OP_SUPPLY || n >= 3'h3) begin
			// [RULE8] one direct write
			step_of = '{1'b1, 1'b0, 1'b1, 1'b0, PORT_DIRECT, sel << DIRECT_LSB};
		end
	endfunction

	scc_hstate_t state;
	scc_op_t     op;
	logic [2:0]  step;
	logic [7:0]  cmd_addr;
	logic [7:0]  cmd_data;
	logic [7:0]  shadow;
	logic [7:0]  rd_byte;
	logic        powered;
	logic        bus_wr;
	logic        bus_rd;
	logic [7:0]  bus_addr;
	logic [7:0]  bus_wdata;
	scc_step_t   cur;
	logic        aw_take;
	logic        cmd_go;

	assign cur     = step_of(op, step, cmd_addr, cmd_data, shadow);
	assign aw_take = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID && !S_AXI_AWREADY;
	assign cmd_go  = aw_take && S_AXI_AWADDR == REG_CMD && state == ST_IDLE && S_AXI_WSTRB != 4'h0;

	// ==========================================================
	// AXI4-Lite write channel
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I) begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= RESP_OKAY;
		end else begin
			S_AXI_AWREADY <= aw_take;
			S_AXI_WREADY  <= aw_take;
			if (aw_take) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= (S_AXI_AWADDR == REG_CMD) ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= '0;
			S_AXI_RRESP   <= RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_RVALID && !S_AXI_ARREADY;
			if (S_AXI_ARVALID && !S_AXI_RVALID && !S_AXI_ARREADY) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA  <= '0;
				S_AXI_RRESP  <= RESP_OKAY;
				if (S_AXI_ARADDR == REG_STATUS) begin
					S_AXI_RDATA[ST_BUSY_BIT]                 <= state != ST_IDLE;
					S_AXI_RDATA[ST_PWR_BIT]                  <= powered;
					S_AXI_RDATA[ST_RD_LSB+:8]               <= rd_byte;
					S_AXI_RDATA[ST_SHADOW_LSB+:8]           <= shadow;
				end else if (S_AXI_ARADDR != REG_CMD) begin
					S_AXI_RRESP <= RESP_SLVERR;
				end
			end else if (S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

	// ==========================================================
	// sequencer
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I) begin
			state    <= ST_IDLE;
			op       <= OP_WRITE;
			step     <= 3'h0;
			cmd_addr <= BYTE_ZERO;
			cmd_data <= BYTE_ZERO;
		end else begin
			case (state)
				ST_IDLE: begin
					if (cmd_go) begin
						op       <= scc_op_t'(S_AXI_WDATA[CMD_OP_LSB+:2]);
						cmd_addr <= S_AXI_WDATA[CMD_ADDR_LSB+:8];
						cmd_data <= S_AXI_WDATA[CMD_DATA_LSB+:8];
						step     <= 3'h0;
						state    <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					if (cur.act && cur.rd) begin
						state <= ST_RDW;
					end else if (cur.act) begin
						state <= ST_GAP;
					end else if (cur.last) begin
						state <= ST_IDLE;
					end else begin
						step <= step + 3'h1;
					end
				end
				ST_GAP: begin
					if (cur.last) begin
						state <= ST_IDLE;
					end else begin
						step  <= step + 3'h1;
						state <= ST_EXEC;
					end
				end
				ST_RDW: begin
					if (BUS.rvalid) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// [RULE11] one byte per strobe
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I) begin
			bus_wr    <= 1'b0;
			bus_rd    <= 1'b0;
			bus_addr  <= BYTE_ZERO;
			bus_wdata <= BYTE_ZERO;
		end else begin
			bus_wr <= state == ST_EXEC && cur.act && !cur.rd;
			bus_rd <= state == ST_EXEC && cur.act && cur.rd;
			if (state == ST_EXEC && cur.act) begin
				bus_addr  <= cur.addr;
				bus_wdata <= cur.data;
			end
		end
	end

	// shadow of port 10h, powered flag, read byte
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I) begin
			shadow  <= BYTE_ZERO;
			powered <= 1'b0;
			rd_byte <= BYTE_ZERO;
		end else begin
			if (state == ST_EXEC && cur.act && !cur.rd && cur.addr == PORT_MOD_CTL0) begin
				shadow <= cur.data;
			end
			if (state == ST_EXEC && cur.clr_pwr) begin
				// [RULE12] powered flag cleared
				powered <= 1'b0;
			end else if (state == ST_EXEC && op == OP_SUPPLY && cur.last) begin
				powered <= cmd_data[NUM_SUPPLY-1:0] != '0;
			end
			if (state == ST_RDW && BUS.rvalid) begin
				rd_byte <= BUS.rdata;
			end
		end
	end

	assign BUS.wr    = bus_wr;
	assign BUS.rd    = bus_rd;
	assign BUS.addr  = bus_addr;
	assign BUS.wdata = bus_wdata;

endmodule

`default_nettype wire

// *** verification/scc_chk.sv ***
// Purpose: bus checker for the switched supply control ends
// Assumes: latch variant on both ends of the watched bus
// Notes:   sees the byte bus only

`timescale 1ns/1ns
`default_nettype none

module scc_chk (
	input  wire logic       CLK_SYS_I,
	input  wire logic       SRST_I,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	input  wire logic [7:0] rdata,
	input  wire logic       rvalid
);
	import scc_pkg::*;
	logic [3:0] sel_q;
	logic       clk_q;
	logic       pd_q;
	logic [7:0] sh_q;
	logic [7:0] ra_q;
	wire        lw = wr && addr == PORT_LATCH;

	// ====
	// helpers
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I) begin
			sel_q <= 4'h0;
			clk_q <= 1'b0;
		end else if (lw) begin
			sel_q <= wdata[SEL_LSB+:4];
			clk_q <= wdata[LATCH_CLK_BIT];
		end
	end
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I)
			pd_q <= 1'b0;
		else if (wr && addr == PORT_MOD_CTL1 && wdata == BYTE_ZERO)
			pd_q <= 1'b1;
		else if (wr && addr == PORT_MOD_CTL0)
			pd_q <= 1'b0;
	end
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I)
			sh_q <= 8'h00;
		else if (wr && addr == PORT_MOD_CTL0)
			sh_q <= wdata;
	end
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I)
			ra_q <= 8'h00;
		else if (rd)
			ra_q <= addr;
	end

	// ====
	// assertions
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (SRST_I);

	a_reset_quiet: assert property ($fell(SRST_I) |-> !wr && !rd && !rvalid)
		else $error("bus active right after reset");
	a_read_answer: assert property (rd |-> ##2 rvalid)
		else $error("read not answered two cycles after strobe");
	a_answer_cause: assert property (rvalid |-> $past(rd, 2) && !$past(rd))
		else $error("read answer without its strobe");
	a_strobe_excl: assert property (!(wr && rd))
		else $error("read and write strobe together");
	a_write_pulse: assert property (wr |=> !wr)
		else $error("write strobe longer than one cycle");
	a_latch_pair: assert property (lw && wdata[LATCH_CLK_BIT] |-> ##2 (lw && !wdata[LATCH_CLK_BIT]))
		else $error("latch write not followed by its clocking write");
	a_latch_keep: assert property (lw && !wdata[LATCH_CLK_BIT] |-> clk_q && wdata[SEL_LSB+:4] == sel_q)
		else $error("clocking write without matching set write");
	a_status_bits: assert property (rvalid && ra_q == PORT_STATUS |-> rdata[0] == 1'b0 && rdata[7:5] == 3'h0)
		else $error("status byte has stray bits");
	a_unmapped_zero: assert property (rvalid && ra_q != PORT_STATUS && (ra_q < PORT_MOD_FIRST || ra_q > PORT_MOD_LAST)
		|-> rdata == BYTE_ZERO)
		else $error("unmapped read not zero");
	a_pdown_order: assert property (wr && addr == PORT_MOD_CTL1 && wdata == BYTE_ZERO
		|-> ##[1:12] (wr && addr == PORT_MOD_CTL0))
		else $error("port 10h not cleared after port 11h");
	a_pdown_keep: assert property (pd_q && wr && addr == PORT_MOD_CTL0 |-> wdata == (sh_q & UPLOAD_MASK))
		else $error("power-down write lost upload flag");
	a_pdown_off: assert property (pd_q && wr && addr == PORT_MOD_CTL0 |-> ##[1:12] (lw && wdata[SEL_LSB+:4] == 4'h0))
		else $error("supplies not switched off last");

	c_latch_pair: cover property (lw ##2 lw);
	c_pdown: cover property (pd_q && wr && addr == PORT_MOD_CTL0);
	c_read: cover property (rd ##2 rvalid);
	c_last_port: cover property (rd && addr == PORT_MOD_LAST);
endmodule

`default_nettype wire

// *** verification/switched_supply_control_test.sv ***
// Purpose: bench for both ends of switched supply control
// Assumes: 20 MHz clock, synchronous reset
// Notes:   second and third bus are driven by the bench

`timescale 1ns/1ns
`default_nettype none

module switched_supply_control_test;
	import scc_pkg::*;
	logic        clk, srst, awvalid, wvalid, bready, arvalid, rready, b_wr, b_rd;
	logic [3:0]  awaddr, araddr, wstrb, oc;
	logic [31:0] wdat;
	logic [7:0]  mrd, b_addr, b_wdata;
	wire         awready, wready, bvalid, arready, rvalid;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdat;
	wire  [3:0]  sup, sup_b, sup_c;
	wire  [15:0] ws_b, rs_b;
	wire  [7:0]  mwd, mwd_b;
	int          err_count, n_tests;
	scc_bus_if bus();
	scc_bus_if bus_b();
	scc_bus_if bus_c();
	assign {bus_b.addr, bus_b.wdata, bus_b.wr, bus_b.rd} = {b_addr, b_wdata, b_wr, b_rd};
	assign {bus_c.addr, bus_c.wdata, bus_c.wr, bus_c.rd} = {b_addr, b_wdata, b_wr, b_rd};

	scc_host_end #(.BENCH(1'b1)) i_scc_host_end (.CLK_SYS_I(clk), .SRST_I(srst), .BUS(bus),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdat),
		.S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready));
	scc_dev_end #(.BENCH(1'b1)) i_scc_dev_end (.CLK_SYS_I(clk), .SRST_I(srst), .BUS(bus), .OVERCURRENT_I(oc),
		.SUPPLY_O(sup), .MOD_WR_STB_O(), .MOD_RD_STB_O(), .MOD_WDATA_O(mwd), .MOD_RDATA_I(mrd));
	scc_dev_end #(.BENCH(1'b1)) i_scc_dev_end_b (.CLK_SYS_I(clk), .SRST_I(srst), .BUS(bus_b),
		.OVERCURRENT_I(oc), .SUPPLY_O(sup_b), .MOD_WR_STB_O(ws_b), .MOD_RD_STB_O(rs_b),
		.MOD_WDATA_O(mwd_b), .MOD_RDATA_I({4'h6, b_addr[3:0]}));
	scc_dev_end #(.BENCH(1'b0)) i_scc_dev_end_c (.CLK_SYS_I(clk), .SRST_I(srst), .BUS(bus_c),
		.OVERCURRENT_I(oc), .SUPPLY_O(sup_c), .MOD_WR_STB_O(), .MOD_RD_STB_O(),
		.MOD_WDATA_O(), .MOD_RDATA_I(mrd));
	scc_chk i_scc_chk (.CLK_SYS_I(clk), .SRST_I(srst), .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr),
		.rd(bus.rd), .rdata(bus.rdata), .rvalid(bus.rvalid));

	// ====
	// shared tasks
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %0h, seen %0h", nm, e, g);
		end
	endtask
	task conclude;
		if (err_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdat <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdat;
		r = rresp;
		rready <= 1'b0;
	endtask
	task cmd(input scc_op_t op, input logic [7:0] a, input logic [7:0] d, output logic [31:0] st);
		logic [1:0] r;
		axi_wr(REG_CMD, (32'(op) << CMD_OP_LSB) | (32'(a) << CMD_ADDR_LSB) | 32'(d), r);
		do begin
			axi_rd(REG_STATUS, st, r);
		end while (st[ST_BUSY_BIT] !== 1'b0);
	endtask
	task bw(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		b_addr <= a;
		b_wdata <= d;
		b_wr <= 1'b1;
		@(posedge clk);
		b_wr <= 1'b0;
		#1;
	endtask
	task br(input logic [7:0] a, output logic [7:0] d, output logic [15:0] s);
		d = 'x;
		@(posedge clk);
		b_addr <= a;
		b_rd <= 1'b1;
		@(posedge clk);
		b_rd <= 1'b0;
		#1 s = rs_b;
		for (int n = 0; n < 8; n++) begin
			@(posedge clk);
			if (bus_b.rvalid) begin
				d = bus_b.rdata;
				break;
			end
		end
	endtask

	// ====
	// scenarios
	task t_supply;
		logic [31:0] st;
		logic [3:0]  v [7];
		v = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hA, 4'h5, 4'hF};
		foreach (v[i]) begin
			cmd(OP_SUPPLY, 8'h00, {4'h0, v[i]}, st);
			chk("supply", v[i], sup);
			chk("powered", 1'b1, st[ST_PWR_BIT]);
			cmd(OP_READ, PORT_STATUS, 8'h00, st);
			chk("status", {3'h0, v[i], 1'b0}, st[15:8]);
		end
	endtask
	task t_overcur;
		logic [31:0] st;
		@(posedge clk);
		oc <= 4'h4;
		repeat (2) @(posedge clk);
		#1 chk("oc supply", 4'hB, sup);
		chk("oc direct variant", 4'h9, sup_c);
		cmd(OP_READ, PORT_STATUS, 8'h00, st);
		chk("oc status", 8'h16, st[15:8]);
		oc <= 4'h0;
	endtask
	task t_modread;
		logic [31:0] st;
		cmd(OP_READ, PORT_MOD_LAST, 8'h00, st);
		chk("module read", mrd, st[15:8]);
		cmd(OP_READ, 8'h40, 8'h00, st);
		chk("unmapped read", 8'h00, st[15:8]);
	endtask
	task t_latch;
		bw(PORT_LATCH, 8'h1E);
		chk("no edge", 4'h0, sup_b);
		bw(PORT_LATCH, 8'h1F);
		chk("rising edge", 4'h0, sup_b);
		bw(PORT_LATCH, 8'h0A);
		chk("falling edge", 4'h5, sup_b);
		bw(PORT_LATCH, 8'h14);
		chk("low again", 4'h5, sup_b);
		chk("direct ignores latch", 4'h0, sup_c);
		bw(PORT_DIRECT, 8'h09);
		chk("direct", 4'h9, sup_c);
		chk("latch ignores direct", 4'h5, sup_b);
	endtask
	task t_decode;
		logic [7:0]  d;
		logic [15:0] s;
		for (int i = 0; i < 16; i++) begin
			bw(8'h10 + 8'(i), 8'h5A ^ 8'(i));
			chk("write strobe", 16'h1 << i, ws_b);
			chk("module wdata", 8'h5A ^ 8'(i), mwd_b);
			br(8'h10 + 8'(i), d, s);
			chk("read strobe", 16'h1 << i, s);
			chk("read byte", 8'h60 | 8'(i), d);
		end
		bw(8'h20, 8'h77);
		chk("stray write", 16'h0, ws_b);
		chk("stray wdata", 8'h55, mwd_b);
		br(8'h0F, d, s);
		chk("stray read", 8'h00, d);
		chk("stray rstrobe", 16'h0, s);
	endtask
	task t_pdown;
		logic [31:0] st;
		cmd(OP_WRITE, PORT_MOD_CTL0, 8'hFF, st);
		cmd(OP_WRITE, PORT_MOD_CTL1, 8'h33, st);
		cmd(OP_SUPPLY, 8'h00, 8'h0F, st);
		cmd(OP_PDOWN, 8'h00, 8'h00, st);
		chk("off supply", 4'h0, sup);
		chk("off flag", 1'b0, st[ST_PWR_BIT]);
		chk("shadow", UPLOAD_MASK, st[23:16]);
		chk("last port byte", UPLOAD_MASK, mwd);
	endtask
	task t_axi;
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(4'h8, d, r);
		chk("bad read resp", RESP_SLVERR, r);
		axi_wr(4'hC, 32'h0, r);
		chk("bad write resp", RESP_SLVERR, r);
		axi_rd(REG_CMD, d, r);
		chk("cmd read", 32'h0, d);
		chk("cmd resp", RESP_OKAY, r);
		wstrb <= 4'h0;
		axi_wr(REG_CMD, (32'(OP_SUPPLY) << CMD_OP_LSB) | 32'h0F, r);
		wstrb <= 4'hF;
		chk("no strobe resp", RESP_OKAY, r);
		axi_rd(REG_STATUS, d, r);
		chk("no strobe status", 32'h0, d);
		chk("no strobe supply", 4'h0, sup);
	endtask

	// ====
	// run
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (30000) @(posedge clk);
		err_count++;
		conclude();
	end
	initial begin
		{srst, awvalid, wvalid, bready, arvalid, rready, b_wr, b_rd} = 8'h80;
		{awaddr, araddr, oc, wdat, b_addr, b_wdata} = '0;
		wstrb = 4'hF;
		mrd = 8'hA5;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1 chk("reset supply", 12'h0, {sup, sup_b, sup_c});
		t_axi();
		t_latch();
		t_decode();
		t_supply();
		t_overcur();
		t_modread();
		t_pdown();
		conclude();
	end
endmodule

`default_nettype wire
